// ==== core/dfc_regs.sv ====
// Filter interval, clock source select and watchdog registers behind AXI4-Lite
// What this block does
// - Pulses shorter than interval are dropped
// - 20-bit interval in 200 ns steps
// - Offset 0x14 enables/disables automatic clock selection
// - Bit 1 reports current clock source
// - Status reads 0 for backplane clock
// - Status reads 1 for onboard oscillator
// - Offset 0x15 bit 0 enables the expiry drive output; the expired flag output is not gated
// - 32-bit watchdog timeout in 100 ns units
// - Offset 0x17 bit 0 shows expiration state
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module dfc_regs #(
   parameter int DIN_W = 8
) (
   input  wire logic             MCLK_I,
   input  wire logic             RST_I,
   input  wire logic [9:0]       S_AXI_AWADDR_I,
   input  wire logic             S_AXI_AWVALID_I,
   output logic                  S_AXI_AWREADY_O,
   input  wire logic [31:0]      S_AXI_WDATA_I,
   input  wire logic [3:0]       S_AXI_WSTRB_I,
   input  wire logic             S_AXI_WVALID_I,
   output logic                  S_AXI_WREADY_O,
   output logic [1:0]            S_AXI_BRESP_O,
   output logic                  S_AXI_BVALID_O,
   input  wire logic             S_AXI_BREADY_I,
   input  wire logic [9:0]       S_AXI_ARADDR_I,
   input  wire logic             S_AXI_ARVALID_I,
   output logic                  S_AXI_ARREADY_O,
   output logic [31:0]           S_AXI_RDATA_O,
   output logic [1:0]            S_AXI_RRESP_O,
   output logic                  S_AXI_RVALID_O,
   input  wire logic             S_AXI_RREADY_I,
   input  wire logic [DIN_W-1:0] DIN_I,
   output logic      [DIN_W-1:0] DIN_FILT_O,
   input  wire logic             BP_CLK_OK_I,
   output logic                  SYS_CLK_ONBOARD_O,
   input  wire logic             WDT_KICK_I,
   output logic                  WDT_EXPIRE_DRIVE_O,
   output logic                  WDT_EXPIRED_O
);
   localparam int FI_W = dfc_pkg::FI_W;

   // Registers
   logic [FI_W-1:0]  glitch_interval_count_reg;
   logic             auto_clock_select_off_reg;
   logic             sys_clock_source_flag_reg;
   logic             watchdog_expiry_action_en_reg;
   logic [31:0]      watchdog_timeout_count_reg;
   logic [31:0]      wdt_elapsed_reg;
   logic             watchdog_expired_flag_reg;
   logic [7:0]       fi_pre_reg;
   logic [7:0]       wdt_pre_reg;
   logic [1:0]       bp_sync_reg;
   logic [1:0]       kick_sync_reg;
   logic             kick_prev_reg;
   logic [DIN_W-1:0] din_s1_reg;
   logic [DIN_W-1:0] din_s2_reg;
   logic             aw_held_reg;
   logic             w_held_reg;
   logic [9:0]       awaddr_reg;
   logic [31:0]      wdata_reg;
   logic [3:0]       wstrb_reg;
   logic             bvalid_reg;
   logic [1:0]       bresp_reg;
   logic             rvalid_reg;
   logic [31:0]      rdata_reg;
   logic [1:0]       rresp_reg;

   // Address index from a byte address
   function automatic logic [7:0] to_idx(input logic [9:0] a);
      return a[9:dfc_pkg::ADDR_LSB];
   endfunction : to_idx

   function automatic logic is_mapped(input logic [7:0] i);
      return i == dfc_pkg::IDX_FILTER || i == dfc_pkg::IDX_CLKSEL
          || i == dfc_pkg::IDX_WDT_EN || i == dfc_pkg::IDX_WDT_STAT
          || i == dfc_pkg::IDX_WDT_TIME;
   endfunction : is_mapped

   // Byte-lane merge of write data into an old value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (s[b]) r[8*b +: 8] = d[8*b +: 8];
      return r;
   endfunction : merge

   // Write channel handshake: address and data taken independently
   wire        aw_take   = S_AXI_AWVALID_I && !aw_held_reg && !bvalid_reg;
   wire        w_take    = S_AXI_WVALID_I && !w_held_reg && !bvalid_reg;
   wire        wr_fire   = aw_held_reg && w_held_reg && !bvalid_reg;
   wire [7:0]  wr_idx    = to_idx(awaddr_reg);
   wire [31:0] fi_merged = merge({12'h000, glitch_interval_count_reg}, wdata_reg, wstrb_reg);
   wire [31:0] ti_merged = merge(watchdog_timeout_count_reg, wdata_reg, wstrb_reg);
   wire        wr_fi     = wr_fire && wr_idx == dfc_pkg::IDX_FILTER;
   wire        wr_cs     = wr_fire && wr_idx == dfc_pkg::IDX_CLKSEL && wstrb_reg[0];
   wire        wr_we     = wr_fire && wr_idx == dfc_pkg::IDX_WDT_EN && wstrb_reg[0];
   wire        wr_ti     = wr_fire && wr_idx == dfc_pkg::IDX_WDT_TIME;
   assign S_AXI_AWREADY_O = !aw_held_reg && !bvalid_reg;
   assign S_AXI_WREADY_O  = !w_held_reg && !bvalid_reg;
   assign S_AXI_BVALID_O  = bvalid_reg;
   assign S_AXI_BRESP_O   = bresp_reg;

   // Read channel decode
   wire [7:0]  rd_idx   = to_idx(S_AXI_ARADDR_I);
   wire        ar_take  = S_AXI_ARVALID_I && !rvalid_reg;
   wire [31:0] rd_value =
      rd_idx == dfc_pkg::IDX_FILTER   ? {12'h000, glitch_interval_count_reg} :
      rd_idx == dfc_pkg::IDX_CLKSEL   ? {30'h0, sys_clock_source_flag_reg, 1'b0} :
      rd_idx == dfc_pkg::IDX_WDT_EN   ? {31'h0, watchdog_expiry_action_en_reg} :
      rd_idx == dfc_pkg::IDX_WDT_STAT ? {31'h0, watchdog_expired_flag_reg} :
      rd_idx == dfc_pkg::IDX_WDT_TIME ? watchdog_timeout_count_reg : 32'h0000_0000;
   assign S_AXI_ARREADY_O = !rvalid_reg;
   assign S_AXI_RVALID_O  = rvalid_reg;
   assign S_AXI_RDATA_O   = rdata_reg;
   assign S_AXI_RRESP_O   = rresp_reg;

   // Bus state
   always_ff @(posedge MCLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= dfc_pkg::RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= dfc_pkg::RESP_OKAY;
      end
      else
      begin
         if (aw_take) aw_held_reg <= 1'b1;
         if (aw_take) awaddr_reg  <= S_AXI_AWADDR_I;
         if (w_take)  w_held_reg  <= 1'b1;
         if (w_take)  wdata_reg   <= S_AXI_WDATA_I;
         if (w_take)  wstrb_reg   <= S_AXI_WSTRB_I;
         if (wr_fire)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= is_mapped(wr_idx) ? dfc_pkg::RESP_OKAY : dfc_pkg::RESP_SLVERR;
         end
         else if (bvalid_reg && S_AXI_BREADY_I)
            bvalid_reg  <= 1'b0;
         if (ar_take)
         begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_value;
            rresp_reg  <= is_mapped(rd_idx) ? dfc_pkg::RESP_OKAY : dfc_pkg::RESP_SLVERR;
         end
         else if (rvalid_reg && S_AXI_RREADY_I)
            rvalid_reg <= 1'b0;
      end
   end

   // Software-written configuration; reserved bits are dropped
   always_ff @(posedge MCLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         glitch_interval_count_reg     <= dfc_pkg::FI_RST;
         auto_clock_select_off_reg     <= 1'b0;
         watchdog_expiry_action_en_reg <= 1'b0;
         watchdog_timeout_count_reg    <= dfc_pkg::WATCHDOG_TIMEOUT_COUNT_RST;
      end
      else
      begin
         if (wr_fi) glitch_interval_count_reg <= fi_merged[FI_W-1:0];
         if (wr_cs) auto_clock_select_off_reg <= wdata_reg[dfc_pkg::BIT_AUTO_OFF];
         if (wr_we) watchdog_expiry_action_en_reg <= wdata_reg[dfc_pkg::BIT_WDT_EN];
         if (wr_ti) watchdog_timeout_count_reg <= ti_merged;
      end
   end

   // Pin synchronisers and step prescalers
   wire fi_tick  = fi_pre_reg == 8'(dfc_pkg::FI_STEP_CYC - 1);
   wire wdt_tick = wdt_pre_reg == 8'(dfc_pkg::WDT_STEP_CYC - 1);
   wire kick     = kick_sync_reg[1] && !kick_prev_reg;
   always_ff @(posedge MCLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         bp_sync_reg   <= 2'b00;
         kick_sync_reg <= 2'b00;
         kick_prev_reg <= 1'b0;
         din_s1_reg    <= '0;
         din_s2_reg    <= '0;
         fi_pre_reg    <= '0;
         wdt_pre_reg   <= '0;
      end
      else
      begin
         bp_sync_reg   <= {bp_sync_reg[0], BP_CLK_OK_I};
         kick_sync_reg <= {kick_sync_reg[0], WDT_KICK_I};
         kick_prev_reg <= kick_sync_reg[1];
         din_s1_reg    <= DIN_I;
         din_s2_reg    <= din_s1_reg;
         fi_pre_reg    <= fi_tick ? 8'h00 : fi_pre_reg + 8'h01;   // 200 ns step
         wdt_pre_reg   <= wdt_tick ? 8'h00 : wdt_pre_reg + 8'h01; // 100 ns step
      end
   end

   // Clock source choice and watchdog timing
   wire src_next = auto_clock_select_off_reg ? 1'b1 : !bp_sync_reg[1];
   wire wdt_restart = kick || wr_ti || watchdog_timeout_count_reg == 32'h0000_0000;
   always_ff @(posedge MCLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         sys_clock_source_flag_reg <= 1'b1;
         wdt_elapsed_reg           <= '0;
         watchdog_expired_flag_reg <= 1'b0;
      end
      else
      begin
         sys_clock_source_flag_reg <= src_next;
         if (wdt_restart)
         begin
            wdt_elapsed_reg           <= '0;
            watchdog_expired_flag_reg <= 1'b0;
         end
         else if (wdt_tick && !watchdog_expired_flag_reg)
         begin
            wdt_elapsed_reg <= wdt_elapsed_reg + 32'h0000_0001;
            if (wdt_elapsed_reg + 32'h0000_0001 >= watchdog_timeout_count_reg)
               watchdog_expired_flag_reg <= 1'b1;
         end
      end
   end

   assign SYS_CLK_ONBOARD_O  = sys_clock_source_flag_reg;
   assign WDT_EXPIRED_O      = watchdog_expired_flag_reg;
   assign WDT_EXPIRE_DRIVE_O = watchdog_expired_flag_reg && watchdog_expiry_action_en_reg;

   // Input glitch filter
   dfc_glitch_filter #(
      .WIDTH (DIN_W),
      .FI_W  (FI_W)
   ) u_filter (
      .clk_i      (MCLK_I),
      .rst_i      (RST_I),
      .tick_i     (fi_tick),
      .interval_i (glitch_interval_count_reg),
      .raw_i      (din_s2_reg),
      .filt_o     (DIN_FILT_O)
   );
endmodule : dfc_regs

// ==== core/dfc_pkg.sv ====
// Shared constants for the filter, clock select and watchdog register slice
package dfc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0]  IDX_FILTER   = 8'h08;
   localparam logic [7:0]  IDX_CLKSEL   = 8'h14;
   localparam logic [7:0]  IDX_WDT_EN   = 8'h15;
   localparam logic [7:0]  IDX_WDT_STAT = 8'h17;
   localparam logic [7:0]  IDX_WDT_TIME = 8'h18;
   localparam int          ADDR_LSB     = 2;
   // Field layout
   localparam int          FI_W         = 20;
   localparam int          BIT_AUTO_OFF = 0;
   localparam int          BIT_SRC_FLAG = 1;
   localparam int          BIT_WDT_EN   = 0;
   localparam int          BIT_WDT_EXP  = 0;
   // Reset values
   localparam logic [19:0] FI_RST       = 20'h0_0000;
   localparam logic [31:0] WATCHDOG_TIMEOUT_COUNT_RST   = 32'h0000_0000;
   // Timing
   localparam int          CLK_MHZ      = 250;
   localparam int          FI_STEP_NS   = 200;
   localparam int          WDT_STEP_NS  = 100;
   localparam int          FI_STEP_CYC  = (FI_STEP_NS * CLK_MHZ) / 1000;
   localparam int          WDT_STEP_CYC = (WDT_STEP_NS * CLK_MHZ) / 1000;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY    = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;
endpackage : dfc_pkg

// ==== core/dfc_glitch_filter.sv ====
// Per-line glitch filter: a level passes only after staying stable for the interval
`timescale 1ns/1ps
module dfc_glitch_filter #(
   parameter int WIDTH = 8,
   parameter int FI_W  = 20
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             tick_i,
   input  wire logic [FI_W-1:0]  interval_i,
   input  wire logic [WIDTH-1:0] raw_i,
   output logic      [WIDTH-1:0] filt_o
);
   logic [WIDTH-1:0] filt_reg;
   logic [FI_W-1:0]  cnt_reg [WIDTH];

   assign filt_o = filt_reg;

   // Each line counts interval steps while its level differs from the output;
   // a change passes only on the step after the count reached the interval, so a
   // partial first step can never let a pulse shorter than the interval through
   for (genvar g = 0; g < WIDTH; g++)
   begin : g_line
      wire differs = raw_i[g] != filt_reg[g];
      wire pass    = differs && (interval_i == '0 || (tick_i && cnt_reg[g] >= interval_i));
      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            cnt_reg[g]  <= '0;
            filt_reg[g] <= 1'b0;
         end
         else if (!differs || pass)
         begin
            cnt_reg[g]  <= '0;                // Level back (short pulse discarded) or change passed
            filt_reg[g] <= raw_i[g];
         end
         else if (tick_i)
            cnt_reg[g]  <= cnt_reg[g] + 1'b1;
      end
   end
endmodule : dfc_glitch_filter

// ==== sim/dfc_regs_props.sv ====
// Port-level assertions for the register slice
`timescale 1ns/1ps
module dfc_regs_props (
   input wire logic        MCLK_I,
   input wire logic        RST_I,
   input wire logic [9:0]  S_AXI_ARADDR_I,
   input wire logic        S_AXI_ARVALID_I,
   input wire logic        S_AXI_ARREADY_O,
   input wire logic        S_AXI_AWVALID_I,
   input wire logic        S_AXI_AWREADY_O,
   input wire logic        S_AXI_WVALID_I,
   input wire logic        S_AXI_WREADY_O,
   input wire logic [1:0]  S_AXI_BRESP_O,
   input wire logic        S_AXI_BVALID_O,
   input wire logic        S_AXI_BREADY_I,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic        S_AXI_RVALID_O,
   input wire logic        S_AXI_RREADY_I,
   input wire logic        BP_CLK_OK_I,
   input wire logic        SYS_CLK_ONBOARD_O,
   input wire logic        WDT_EXPIRE_DRIVE_O,
   input wire logic        WDT_EXPIRED_O
);
   localparam logic [9:0] A_FI = {dfc_pkg::IDX_FILTER, 2'b00};
   localparam logic [9:0] A_WS = {dfc_pkg::IDX_WDT_STAT, 2'b00};
   logic [9:0] rd_addr_reg;
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (RST_I);
   // Remember the address of the read in flight
   always_ff @(posedge MCLK_I or posedge RST_I)
      if (RST_I)
         rd_addr_reg <= 10'h000;
      else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
         rd_addr_reg <= S_AXI_ARADDR_I;
   // Bus answers and their holding
   wr_answer_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
      && S_AXI_WREADY_O |-> ##[1:2] S_AXI_BVALID_O) else $error("write not answered");
   rd_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("read not answered");
   b_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O
      && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
   r_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O
      && $stable(S_AXI_RDATA_O)) else $error("read data dropped");
   // Field contents and status outputs
   fi_reserved_a: assert property (S_AXI_RVALID_O && rd_addr_reg == A_FI
      |-> S_AXI_RDATA_O[31:20] == 12'h000) else $error("filter upper bits not zero");
   exp_status_a: assert property ($rose(S_AXI_RVALID_O) && rd_addr_reg == A_WS
      |-> S_AXI_RDATA_O[31:1] == 31'h0000_0000 && (S_AXI_RDATA_O[0] == WDT_EXPIRED_O
      || S_AXI_RDATA_O[0] == $past(WDT_EXPIRED_O))) else $error("expiry status wrong");
   onboard_sel_a: assert property (!BP_CLK_OK_I [*6] |-> SYS_CLK_ONBOARD_O)
      else $error("oscillator not selected without backplane clock");
   drive_gate_a: assert property (WDT_EXPIRE_DRIVE_O |-> WDT_EXPIRED_O)
      else $error("expiry drive without expiry");
   cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
   cover property (S_AXI_RVALID_O && rd_addr_reg == A_WS);
   cover property (WDT_EXPIRE_DRIVE_O);
endmodule : dfc_regs_props
bind dfc_regs dfc_regs_props i_dfc_regs_props (.MCLK_I(MCLK_I), .RST_I(RST_I),
   .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
   .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
   .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
   .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
   .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
   .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
   .S_AXI_RREADY_I(S_AXI_RREADY_I), .BP_CLK_OK_I(BP_CLK_OK_I),
   .SYS_CLK_ONBOARD_O(SYS_CLK_ONBOARD_O), .WDT_EXPIRE_DRIVE_O(WDT_EXPIRE_DRIVE_O),
   .WDT_EXPIRED_O(WDT_EXPIRED_O));

// ==== sim/test_dio_filter_clock_watchdog_config.sv ====
// Self-checking bench for the register slice
`timescale 1ns/1ps
module test_dio_filter_clock_watchdog_config;
   localparam logic [9:0] A_FI = {dfc_pkg::IDX_FILTER, 2'b00};
   localparam logic [9:0] A_CS = {dfc_pkg::IDX_CLKSEL, 2'b00};
   localparam logic [9:0] A_WE = {dfc_pkg::IDX_WDT_EN, 2'b00};
   localparam logic [9:0] A_WS = {dfc_pkg::IDX_WDT_STAT, 2'b00};
   localparam logic [9:0] A_WT = {dfc_pkg::IDX_WDT_TIME, 2'b00};
   localparam logic [1:0] OK = dfc_pkg::RESP_OKAY;
   logic mclk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, bp_ok = 1'b1, kick = 1'b0;
   logic [9:0] awaddr = 10'h000, araddr = 10'h000;
   logic [31:0] wdata = 32'h0000_0000, rdata, seed = 32'h0000_002b, d;
   logic [7:0] din = 8'h00, filt;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, onboard, drv, expd;
   int fail_count = 0, total_checks = 0;
   dfc_regs i_dfc_regs (.MCLK_I(mclk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr),
      .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
      .S_AXI_RREADY_I(rready), .DIN_I(din), .DIN_FILT_O(filt), .BP_CLK_OK_I(bp_ok),
      .SYS_CLK_ONBOARD_O(onboard), .WDT_KICK_I(kick), .WDT_EXPIRE_DRIVE_O(drv),
      .WDT_EXPIRED_O(expd));
   // 250 MHz clock
   always #2 mclk = ~mclk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   function automatic logic [31:0] exp_cs(input logic ok, input logic off);
      return {30'h0000_0000, off | ~ok, 1'b0};
   endfunction : exp_cs
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   // Write one word; bready stands from the request until bvalid is seen
   task automatic axi_write(input logic [9:0] a, input logic [31:0] v, input logic [1:0] er);
      logic aw, w, done;
      logic [1:0] r;
      @(posedge mclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(negedge mclk);
         aw = awvalid && awready;
         w = wvalid && wready;
         done = bvalid;
         r = bresp;
         @(posedge mclk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (done) bready <= 1'b0;
      end while (!done);
      check({30'h0000_0000, r}, {30'h0000_0000, er});
   endtask : axi_write
   // Read one word and compare data and response
   task automatic axi_read(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ar, done;
      logic [31:0] v;
      logic [1:0] r;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(negedge mclk);
         ar = arvalid && arready;
         done = rvalid;
         v = rdata;
         r = rresp;
         @(posedge mclk);
         if (ar) arvalid <= 1'b0;
         if (done) rready <= 1'b0;
      end while (!done);
      check(v, ed);
      check({30'h0000_0000, r}, {30'h0000_0000, er});
   endtask : axi_read
   // Hang guard
   initial
   begin
      #200_000;
      fail_count++;
      print_verdict();
   end
   // Main sequence
   initial
   begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      axi_read(A_FI, 32'h0000_0000, OK);
      axi_read(A_WT, 32'h0000_0000, OK);
      axi_read(A_WS, 32'h0000_0000, OK);
      // Reserved filter bits are always written as zeros
      for (int i = 0; i < 6; i++)
      begin
         seed = xs(seed);
         d = (i == 0) ? 32'hFFFF_FFFF : seed;
         axi_write(A_FI, d & 32'h000F_FFFF, OK);
         axi_read(A_FI, d & 32'h000F_FFFF, OK);
         axi_write(A_WT, ~d, OK);
         axi_read(A_WT, ~d, OK);
      end
      axi_write(10'h0F0, seed, dfc_pkg::RESP_SLVERR);
      axi_read(10'h0F0, 32'h0000_0000, dfc_pkg::RESP_SLVERR);
      for (int i = 0; i < 4; i++)
      begin
         bp_ok <= i[0];
         axi_write(A_CS, {31'h0000_0000, i[1]}, OK);
         repeat (8) @(posedge mclk);
         axi_read(A_CS, exp_cs(i[0], i[1]), OK);
         d = exp_cs(i[0], i[1]);
         check({31'h0000_0000, onboard}, {31'h0000_0000, d[1]});
      end
      axi_write(A_CS, 32'h0000_0000, OK);
      axi_write(A_WE, 32'h0000_0001, OK);
      axi_read(A_WE, 32'h0000_0001, OK);
      axi_write(A_WT, 32'h0000_0002, OK);
      check({30'h0000_0000, expd, drv}, 32'h0000_0000);
      repeat (2 * dfc_pkg::WDT_STEP_CYC + 30) @(posedge mclk);
      check({30'h0000_0000, expd, drv}, 32'h0000_0003);
      axi_read(A_WS, 32'h0000_0001, OK);
      axi_write(A_WE, 32'h0000_0000, OK);
      check({30'h0000_0000, expd, drv}, 32'h0000_0002);
      kick <= 1'b1;
      repeat (8) @(posedge mclk);
      check({31'h0000_0000, expd}, 32'h0000_0000);
      kick <= 1'b0;
      axi_write(A_WT, 32'h0000_0000, OK);
      axi_write(A_FI, 32'h0000_0001, OK);
      // A pulse shorter than one step must never show on the output
      din <= 8'hFF;
      for (int k = 0; k < 40; k++)
      begin
         @(posedge mclk);
         if (k == 19) din <= 8'h00;
         @(negedge mclk);
         check({24'h00_0000, filt}, 32'h0000_0000);
      end
      repeat (150) @(posedge mclk);
      check({24'h00_0000, filt}, 32'h0000_0000);
      d = {24'h00_0000, seed[7:0] | 8'h01};
      din <= d[7:0];
      repeat (250) @(posedge mclk);
      check({24'h00_0000, filt}, d);
      axi_write(A_FI, 32'h0000_0000, OK);
      din <= ~d[7:0];
      repeat (8) @(posedge mclk);
      check({24'h00_0000, filt}, {24'h00_0000, ~d[7:0]});
      print_verdict();
   end
endmodule : test_dio_filter_clock_watchdog_config
